// ---- rtl/remote_auth_pkg.sv ----
// Constants and carrier types for the remote access challenge gate
package remote_auth_pkg;
	localparam int PW_MAX = 16;
	localparam int IDX_W = 5;
	localparam int CHAL_LEN = 6;
	localparam int CHAL_LINES = 3;
	localparam int MAX_TRIES = 3;
	localparam int LOCK_MIN = 15;
	localparam int CLK_MHZ = 100;
	localparam longint LOCK_CYC = longint'(LOCK_MIN) * 60 * CLK_MHZ * 1000000;
	localparam logic [15:0] LFSR_SEED = 16'hACE1;
	localparam logic [15:0] LFSR_TAPS = 16'hB400;

	typedef enum logic [4:0] {
		ST_IDLE = 5'b0_0001,
		ST_CHAL = 5'b0_0010,
		ST_REPLY = 5'b0_0100,
		ST_OPEN = 5'b0_1000,
		ST_DROP = 5'b1_0000
	} auth_state_t;

	// Command classes handed over by the command parser
	typedef enum logic [1:0] {
		CMD_PLAIN = 2'h0,
		CMD_LISTING = 2'h1,
		CMD_QUERY = 2'h2,
		CMD_RESET = 2'h3
	} cmd_class_t;

	typedef struct packed {
		logic valid;
		cmd_class_t cls;
		logic [7:0] data;
	} cmd_t;

	typedef struct packed {
		logic valid;
		logic last;
		logic [IDX_W-1:0] pos;
	} chal_t;
endpackage

// ---- rtl/remote_access_challenge_auth.sv ----
// Challenge-response gate in front of the command set for a remote station
// How it works
// [R1] Refuse access without password and remote callsign
// [R2] On connect send three lines of positions
// [R3] Station picks one line, maps positions to characters
// [R4] Station replies one character per position
// [R5] Compare case-sensitive, spaces count as characters
// [R6] Wrong reply triggers fresh three lines
// [R7] Three failures: drop link, lock fifteen minutes
// [R8] Disconnect mid-challenge also starts lockout
// [R9] Authenticated session passes every command through
// [R10] Reset-causing command ends the remote session
// [R11] Ordered-link data goes to serial port
// [R12] Listing returns nothing, single query returns setting
// [R13] Positions pseudo-random within stored password length
`timescale 1ns/1ps
module remote_access_challenge_auth
	import remote_auth_pkg::*;
#(
	parameter longint LOCK_CYCLES = LOCK_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Configuration
	input wire logic [PW_MAX*8-1:0] password_text,
	input wire logic [IDX_W-1:0] password_len,
	input wire logic remote_access_callsign_set,
	// Link events
	input wire logic link_connect,
	input wire logic link_disconnect,
	// Reply characters from the station
	input wire logic rx_valid,
	input wire logic [7:0] rx_char,
	input wire logic rx_eol,
	// Commands from the parsed session
	input wire cmd_t cmd_in,
	// Data from links ordered by the remote session
	input wire logic fwd_valid,
	input wire logic [7:0] fwd_char,
	// Challenge output
	output chal_t chal_out,
	// Link control
	output logic link_drop,
	output logic connect_refuse,
	output logic session_open,
	// Command pass-through
	output cmd_t cmd_out,
	output logic resp_enable,
	// Serial port
	output logic serial_valid,
	output logic [7:0] serial_char
);
	localparam int CNT_W = 40;
	localparam int TRY_W = 2;
	localparam int SLOTS = CHAL_LINES * CHAL_LEN;

	typedef struct packed {
		auth_state_t st;
		logic [15:0] lfsr;
		logic [SLOTS*IDX_W-1:0] slot;
		logic [4:0] emit;
		logic [2:0] rpos;
		logic [CHAL_LINES-1:0] match;
		logic [TRY_W-1:0] tries;
		logic [CNT_W-1:0] lock;
		chal_t chal;
		logic drop;
		logic refuse;
		logic open;
		cmd_t cmd;
		logic resp;
		logic sv;
		logic [7:0] sc;
	} state_t;

	state_t r, n;

	function automatic logic [15:0] lfsr_step(input logic [15:0] v);
		lfsr_step = v[0] ? ((v >> 1) ^ LFSR_TAPS) : (v >> 1);
	endfunction

	// Modulo by length keeps every position inside the password
	function automatic logic [IDX_W-1:0] pick(input logic [15:0] v,
			input logic [IDX_W-1:0] len);
		logic [15:0] m;
		m = v % {11'h000, len};
		pick = m[IDX_W-1:0] + 5'h01;
	endfunction

	function automatic logic [7:0] pw_char(input logic [PW_MAX*8-1:0] pw,
			input logic [IDX_W-1:0] p);
		pw_char = pw[(p-5'h01)*8 +: 8];
	endfunction

	wire logic cfg_ok = (password_len != '0) && remote_access_callsign_set;
	wire logic locked = r.lock != '0;
	// One draw feeds both the stored slot and the number sent
	wire logic [IDX_W-1:0] draw = pick(r.lfsr, password_len);

	always_comb begin
		n = r;
		n.lfsr = lfsr_step(r.lfsr);
		n.chal = '0;
		n.drop = 1'b0;
		n.refuse = 1'b0;
		n.cmd = '0;
		n.sv = 1'b0;
		if (locked) begin
			n.lock = r.lock - 40'h00_0000_0001;
		end
		case (r.st)
			ST_IDLE: begin
				n.open = 1'b0;
				n.resp = 1'b0;
				if (link_connect) begin
					if (!cfg_ok || locked) begin
						n.refuse = 1'b1; // [R1] [R7]
						n.drop = 1'b1;
					end else begin
						n.tries = '0;
						n.emit = '0;
						n.st = ST_CHAL;
					end
				end
			end
			ST_CHAL: begin
				// One fresh position per cycle, sent as it is drawn
				n.slot[r.emit*IDX_W +: IDX_W] = draw; // [R13]
				n.chal.valid = 1'b1; // [R2] [R6]
				n.chal.pos = draw;
				n.chal.last = (r.emit % CHAL_LEN) == CHAL_LEN - 1;
				if (r.emit == 5'(SLOTS - 1)) begin
					n.st = ST_REPLY;
					n.rpos = '0;
					n.match = '1;
				end else begin
					n.emit = r.emit + 5'h01;
				end
			end
			ST_REPLY: begin
				if (rx_valid && r.rpos < 3'(CHAL_LEN)) begin
					for (int l = 0; l < CHAL_LINES; l++) begin
						// Exact byte compare: case and spaces both matter
						if (rx_char != pw_char(password_text,
								r.slot[(l*CHAL_LEN + r.rpos)*IDX_W +: IDX_W]))
							n.match[l] = 1'b0; // [R5] [R3] [R4]
					end
					n.rpos = r.rpos + 3'h1;
				end else if (rx_valid) begin
					n.match = '0; // [R4]
				end
				if (rx_eol) begin
					if (r.rpos == 3'(CHAL_LEN) && r.match != '0) begin
						n.st = ST_OPEN;
						n.open = 1'b1;
					end else if (r.tries == TRY_W'(MAX_TRIES - 1)) begin
						n.st = ST_DROP; // [R7]
					end else begin
						n.tries = r.tries + 2'h1;
						n.emit = '0;
						n.st = ST_CHAL; // [R6]
					end
				end
			end
			ST_OPEN: begin
				n.resp = 1'b1;
				if (cmd_in.valid) begin
					n.cmd = cmd_in; // [R9]
					// Listing too large for the link, so its text is muted
					n.resp = cmd_in.cls != CMD_LISTING; // [R12]
					if (cmd_in.cls == CMD_RESET) begin
						n.drop = 1'b1; // [R10]
						n.open = 1'b0;
						n.st = ST_IDLE;
					end
				end
			end
			ST_DROP: begin
				n.drop = 1'b1;
				n.lock = CNT_W'(LOCK_CYCLES); // [R7]
				n.st = ST_IDLE;
			end
			default: begin
				n.st = ST_IDLE;
			end
		endcase
		if (link_disconnect && (r.st == ST_CHAL || r.st == ST_REPLY)) begin
			n.lock = CNT_W'(LOCK_CYCLES); // [R8]
			n.st = ST_IDLE;
		end else if (link_disconnect && r.st == ST_OPEN) begin
			n.open = 1'b0;
			n.st = ST_IDLE;
		end
		if (fwd_valid) begin
			n.sv = 1'b1; // [R11]
			n.sc = fwd_char;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			r <= '0;
			r.st <= ST_IDLE;
			r.lfsr <= LFSR_SEED;
		end else begin
			r <= n;
		end
	end

	assign chal_out = r.chal;
	assign link_drop = r.drop;
	assign connect_refuse = r.refuse;
	assign session_open = r.open;
	assign cmd_out = r.cmd;
	assign resp_enable = r.resp;
	assign serial_valid = r.sv;
	assign serial_char = r.sc;

	refuse_cfg_a: assert property (@(posedge clk) disable iff (!rstn) // [R1]
		(r.st == ST_IDLE && link_connect && !cfg_ok) |=> connect_refuse)
		else $error("connect without config not refused");
	chal_count_a: assert property (@(posedge clk) disable iff (!rstn) // [R2]
		$rose(r.st == ST_REPLY) |-> (chal_out.valid && chal_out.last
		&& $past(chal_out.last, 6) && $past(chal_out.last, 12)
		&& $past(chal_out.valid, 17) && !$past(chal_out.valid, 18)))
		else $error("challenge set is not three lines of six");
	pos_range_a: assert property (@(posedge clk) disable iff (!rstn) // [R13]
		chal_out.valid |-> (chal_out.pos >= 5'h01
		&& chal_out.pos <= password_len))
		else $error("challenge position out of range");
	retry_a: assert property (@(posedge clk) disable iff (!rstn) // [R6]
		(r.st == ST_REPLY && rx_eol && n.st == ST_CHAL) |=> ##1 chal_out.valid)
		else $error("no fresh challenge after bad reply");
	lock_drop_a: assert property (@(posedge clk) disable iff (!rstn) // [R7]
		(r.st == ST_DROP) |=> (link_drop && locked))
		else $error("third failure did not drop and lock");
	lock_refuse_a: assert property (@(posedge clk) disable iff (!rstn) // [R7]
		(locked && r.st == ST_IDLE && link_connect) |=> connect_refuse)
		else $error("connect accepted during lockout");
	disc_lock_a: assert property (@(posedge clk) disable iff (!rstn) // [R8]
		(link_disconnect && (r.st == ST_CHAL || r.st == ST_REPLY)) |=> locked)
		else $error("disconnect mid-challenge not penalised");
	pass_cmd_a: assert property (@(posedge clk) disable iff (!rstn) // [R9]
		(r.st == ST_OPEN && cmd_in.valid) |=> (cmd_out == $past(cmd_in)))
		else $error("command not passed through");
	reset_end_a: assert property (@(posedge clk) disable iff (!rstn) // [R10]
		(r.st == ST_OPEN && cmd_in.valid && cmd_in.cls == CMD_RESET)
		|=> (link_drop && !session_open))
		else $error("reset command kept session");
	serial_fwd_a: assert property (@(posedge clk) disable iff (!rstn) // [R11]
		fwd_valid |=> (serial_valid && serial_char == $past(fwd_char)))
		else $error("link data not sent to serial");
	listing_mute_a: assert property (@(posedge clk) disable iff (!rstn) // [R12]
		(r.st == ST_OPEN && cmd_in.valid && cmd_in.cls == CMD_LISTING)
		|=> !resp_enable)
		else $error("listing response not muted");

	chal_first_a: assert property (@(posedge clk) disable iff (!rstn) // [R2]
		(r.st == ST_IDLE && link_connect && cfg_ok && !locked)
		|=> ##1 chal_out.valid)
		else $error("challenge not sent after connect");
	refuse_idle_a: assert property (@(posedge clk) disable iff (!rstn) // [R1]
		(r.st == ST_IDLE && link_connect && !cfg_ok) |=> (r.st == ST_IDLE))
		else $error("unconfigured connect left idle");
	refuse_drop_a: assert property (@(posedge clk) disable iff (!rstn) // [R1]
		connect_refuse |-> link_drop)
		else $error("refused connect not dropped");
	gate_closed_a: assert property (@(posedge clk) disable iff (!rstn) // [R1]
		(r.st != ST_OPEN) |=> !cmd_out.valid)
		else $error("command passed without access");
	idle_quiet_a: assert property (@(posedge clk) disable iff (!rstn) // [R1]
		(r.st == ST_IDLE) |=> !resp_enable)
		else $error("responses enabled without access");
	short_reply_a: assert property (@(posedge clk) disable iff (!rstn) // [R4]
		(r.st == ST_REPLY && rx_eol && r.rpos != 3'(CHAL_LEN))
		|=> !session_open)
		else $error("short reply opened the session");
	third_fail_a: assert property (@(posedge clk) disable iff (!rstn) // [R7]
		(r.st == ST_REPLY && rx_eol && !link_disconnect
		&& r.tries == TRY_W'(MAX_TRIES - 1) && r.rpos != 3'(CHAL_LEN))
		|=> (r.st == ST_DROP))
		else $error("third failure did not end the attempt");
	lock_start_a: assert property (@(posedge clk) disable iff (!rstn) // [R7]
		$rose(locked) |-> (r.lock == CNT_W'(LOCK_CYCLES)))
		else $error("lockout did not start at full length");
	lock_down_a: assert property (@(posedge clk) disable iff (!rstn) // [R7]
		(locked && r.st == ST_IDLE) |=> (r.lock < $past(r.lock)))
		else $error("lockout counter not running");
	chal_unlocked_a: assert property (@(posedge clk) disable iff (!rstn) // [R7]
		(r.st == ST_CHAL || r.st == ST_REPLY) |-> !locked)
		else $error("challenge running during lockout");
	drop_idle_a: assert property (@(posedge clk) disable iff (!rstn) // [R10]
		(r.st == ST_OPEN && cmd_in.valid && cmd_in.cls == CMD_RESET)
		|=> (r.st == ST_IDLE))
		else $error("reset command left the gate open");
	serial_only_a: assert property (@(posedge clk) disable iff (!rstn) // [R11]
		!fwd_valid |=> !serial_valid)
		else $error("serial output without link data");
	query_resp_a: assert property (@(posedge clk) disable iff (!rstn) // [R12]
		(r.st == ST_OPEN && cmd_in.valid && cmd_in.cls == CMD_QUERY)
		|=> resp_enable)
		else $error("single query response muted");
	open_resp_a: assert property (@(posedge clk) disable iff (!rstn) // [R12]
		($rose(session_open) && !cmd_in.valid) |=> resp_enable)
		else $error("responses not enabled after access");
endmodule

// ---- test/remote_station.sv ----
// Remote station model that decodes one challenge line and replies
`timescale 1ns/1ps
module remote_station
	import remote_auth_pkg::*;
(
	// Clock and bench control
	input wire logic clk,
	input wire logic en,
	input wire logic bad,
	input wire logic [1:0] pick,
	// Challenge and password
	input wire chal_t chal_out,
	input wire logic [PW_MAX*8-1:0] password_text,
	// Reply
	output logic rx_valid,
	output logic [7:0] rx_char,
	output logic rx_eol
);
	logic [IDX_W-1:0] pos_q[$];
	int line = 0;
	int p;
	logic send = 1'b0;
	initial begin
		rx_valid = 1'b0;
		rx_char = 8'h00;
		rx_eol = 1'b0;
	end
	always @(posedge clk) begin
		rx_valid <= 1'b0;
		rx_eol <= 1'b0;
		// Idle char toggles so a stale value never matches by luck
		rx_char <= ~rx_char;
		if (!en) begin
			pos_q.delete();
			line = 0;
		end else if (send) begin
			if (pos_q.size() > 0) begin
				p = pos_q.pop_front();
				rx_valid <= 1'b1;
				rx_char <= password_text[(p-1)*8+:8] ^
					{2'b00, bad, 5'h00};
			end else begin
				rx_eol <= 1'b1;
				send <= 1'b0;
			end
		end else if (chal_out.valid) begin
			if (line == pick)
				pos_q.push_back(chal_out.pos);
			if (chal_out.last)
				line = line + 1;
			if (chal_out.last && line == CHAL_LINES) begin
				line = 0;
				send <= 1'b1;
			end
		end
	end
endmodule

// ---- test/test_remote_access_challenge_auth.sv ----
// Self-checking bench for the remote access challenge gate
`timescale 1ns/1ps
module test_remote_access_challenge_auth
	import remote_auth_pkg::*;
;
	localparam int LOCK = 50;
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [PW_MAX*8-1:0] pw = '0;
	logic [IDX_W-1:0] pw_len = '0;
	logic cs_set = 1'b0;
	logic link_connect = 1'b0;
	logic link_disconnect = 1'b0;
	logic en = 1'b1;
	logic bad = 1'b0;
	logic [1:0] pick = 2'h0;
	logic rx_valid, rx_eol, fwd_valid = 1'b0;
	logic [7:0] rx_char, fwd_char = 8'h00;
	cmd_t cmd_in = '0;
	cmd_t cmd_out;
	chal_t chal_out;
	logic link_drop, connect_refuse, session_open, resp_enable, serial_valid;
	logic [7:0] serial_char;
	int n_fail = 0;
	int tests_run = 0;
	logic [31:0] seed = 32'h0000_41c6;
	logic [CHAL_LINES*CHAL_LEN*IDX_W-1:0] prev_set = '0;

	remote_access_challenge_auth #(.LOCK_CYCLES(LOCK)) i_dut (
		.clk, .rstn, .password_text(pw), .password_len(pw_len),
		.remote_access_callsign_set(cs_set), .link_connect, .link_disconnect,
		.rx_valid, .rx_char, .rx_eol, .cmd_in, .fwd_valid, .fwd_char,
		.chal_out, .link_drop, .connect_refuse, .session_open, .cmd_out,
		.resp_enable, .serial_valid, .serial_char);
	remote_station i_stn (.clk, .en, .bad, .pick, .chal_out,
		.password_text(pw), .rx_valid, .rx_char, .rx_eol);

	initial begin
		forever #5 clk = ~clk;
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	function automatic logic sel(input int k);
		case (k)
			0: return session_open;
			1: return link_drop;
			2: return chal_out.valid;
			default: return connect_refuse;
		endcase
	endfunction

	task automatic end_sim;
		$display("Checks %0d, mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
			input string m);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask

	task automatic wait_on(input int k, input int lim);
		int n;
		n = 0;
		while (sel(k) !== 1'b1 && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (sel(k) !== 1'b1) begin
			n_fail++;
			$display("ERROR %0t wait %0d expired", $time, k);
			end_sim();
		end
	endtask

	task automatic pulse(input logic dis);
		@(posedge clk);
		link_connect <= !dis;
		link_disconnect <= dis;
		@(posedge clk);
		link_connect <= 1'b0;
		link_disconnect <= 1'b0;
		#1;
	endtask

	task automatic refused;
		pulse(1'b0);
		wait_on(3, 4);
		chk(link_drop, 1, "drop with refuse");
	endtask

	task automatic chal_set;
		int nl;
		logic [CHAL_LINES*CHAL_LEN*IDX_W-1:0] cur;
		nl = 0;
		cur = '0;
		wait_on(2, 20);
		for (int i = 0; i < CHAL_LINES*CHAL_LEN; i++) begin
			chk(chal_out.valid, 1, "chal pulse");
			chk(chal_out.pos >= 1 && chal_out.pos <= pw_len, 1, "pos");
			chk(chal_out.last, i % CHAL_LEN == CHAL_LEN - 1, "eol");
			nl += chal_out.last;
			cur = (cur << IDX_W) | chal_out.pos;
			@(posedge clk);
			#1;
		end
		chk(nl, CHAL_LINES, "lines");
		chk(cur != prev_set, 1, "fresh set");
		prev_set = cur;
	endtask

	task automatic open_session;
		pick <= 2'(rnd() % 3);
		bad <= 1'b0;
		pulse(1'b0);
		chal_set();
		wait_on(0, 40);
		chk(session_open, 1, "open");
	endtask

	task automatic cmd(input cmd_class_t c, input logic [7:0] d);
		@(posedge clk);
		cmd_in <= '{1'b1, c, d};
		@(posedge clk);
		cmd_in.valid <= 1'b0;
		#1;
		chk(cmd_out, {1'b1, c, d}, "cmd pass");
		// Mute stands only in the cycle after the listing
		chk(resp_enable, c != CMD_LISTING, "resp");
	endtask

	initial begin
		repeat (16) @(posedge clk);
		rstn <= 1'b1;
		cs_set <= 1'b1;
		refused();
		@(posedge clk);
		// Space at position two keeps space matching exercised
		pw_len <= IDX_W'(4 + rnd() % 13);
		for (int k = 0; k < PW_MAX; k++)
			pw[k*8+:8] <= (k == 1) ? 8'h20 :
				8'h41 + 8'(rnd() % 26) + 8'(rnd() & 32'h0000_0020);
		cs_set <= 1'b0;
		refused();
		cs_set <= 1'b1;
		for (int r = 0; r < 3; r++) begin
			open_session();
			for (int c = 0; c < 3; c++)
				cmd(cmd_class_t'(c), 8'(rnd()));
			@(posedge clk);
			fwd_valid <= 1'b1;
			fwd_char <= 8'(r + 8'h30);
			@(posedge clk);
			fwd_valid <= 1'b0;
			#1;
			chk({serial_valid, serial_char}, {1'b1, 8'(r + 8'h30)},
				"ser");
			cmd(CMD_RESET, 8'h00);
			wait_on(1, 3);
			chk(session_open, 0, "closed by reset");
		end
		bad <= 1'b1;
		pulse(1'b0);
		for (int t = 0; t < MAX_TRIES; t++)
			chal_set();
		wait_on(1, 40);
		refused();
		repeat (LOCK + 10) @(posedge clk);
		open_session();
		pulse(1'b1);
		chk(session_open, 0, "closed by leave");
		en <= 1'b0;
		pulse(1'b0);
		wait_on(2, 10);
		pulse(1'b1);
		en <= 1'b1;
		refused();
		end_sim();
	end
endmodule
